// File: hufc_pkg.sv
// Package for the host UART: register map, fields, resets, timing counts
`default_nettype none
package hufc_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_RXDATA = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // ------------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------------
   localparam int CTRL_FLOW = 0;
   localparam int CTRL_PAREN = 1;
   localparam int CTRL_PARODD = 2;
   localparam int CTRL_STOP2 = 3;
   localparam int CTRL_FRAMING = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // Status fields
   localparam int STAT_TXBUSY = 0;
   localparam int STAT_TXFULL = 1;
   localparam int STAT_RXVALID = 2;
   localparam int STAT_PARERR = 3;
   localparam int STAT_FRAMERR = 4;
   localparam int STAT_OVERRUN = 5;
   localparam int STAT_CTSLOW = 6;
   localparam int STAT_RTSLOW = 7;

   // ------------------------------------------------------------------
   // Timing: 10 MHz clock, 16x oversampling
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int OVERSAMPLE = 16;
   localparam int DEFAULT_BAUD = 115_200;
   localparam int MIN_BAUD = 1_200;
   localparam int MAX_BAUD = 921_600;
   // Tick divisor = clock / (16 * baud), rounded to nearest
   localparam logic [15:0] BAUD_DIV_RESET =
      16'((CLK_HZ + (OVERSAMPLE * DEFAULT_BAUD) / 2)
          / (OVERSAMPLE * DEFAULT_BAUD));
   localparam int DATA_BITS = 8;

   typedef enum logic [1:0] {
      HUFC_RESP_OK,
      HUFC_RESP_ERR
   } hufc_resp_t;

endpackage
`default_nettype wire

// File: hufc_line_if.sv
// Interface carrying the serial engine's user-side signals
`timescale 1ns/1ps
`default_nettype none
interface hufc_line_if;
   logic tick;
   logic parEn;
   logic parOdd;
   logic stop2;
   logic txGo;
   logic [7:0] txByte;
   logic txBusy;
   logic rxDone;
   logic [7:0] rxByte;
   logic rxParErr;
   logic rxFrameErr;

   modport ctl (
      output tick, parEn, parOdd, stop2, txGo, txByte,
      input txBusy, rxDone, rxByte, rxParErr, rxFrameErr
   );
   modport eng (
      input tick, parEn, parOdd, stop2, txGo, txByte,
      output txBusy, rxDone, rxByte, rxParErr, rxFrameErr
   );
endinterface
`default_nettype wire

// File: hufc_serial_engine.sv
// Character transmitter and receiver, 16x oversampled
`timescale 1ns/1ps
`default_nettype none
module hufc_serial_engine (
   input wire logic clock,
   input wire logic rst,
   input wire logic rxPin,
   output logic txPin,
   hufc_line_if.eng ln
);

   // ------------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------------
   // Parity bit for eight data bits
   function automatic logic parityOf(input logic [7:0] d, input logic odd);
      parityOf = (^d) ^ odd;
   endfunction

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
   } hufc_bit_t;

   // ------------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------------
   hufc_bit_t txSt_q;
   logic [3:0] txSub_q;
   logic [2:0] txIdx_q;
   logic txStopN_q;
   logic [7:0] txSh_q;

   assign ln.txBusy = (txSt_q != ST_IDLE);

   // start, LSB first data, parity, stops
   always_ff @(posedge clock) begin
      if (rst) begin
         txSt_q <= ST_IDLE;
         txSub_q <= 4'h0;
         txIdx_q <= 3'h0;
         txStopN_q <= 1'b0;
         txSh_q <= 8'h00;
         txPin <= 1'b1;
      end else if (txSt_q == ST_IDLE) begin
         txPin <= 1'b1;
         if (ln.txGo) begin
            txSh_q <= ln.txByte;
            txSt_q <= ST_START;
            txSub_q <= 4'h0;
         end
      end else if (ln.tick) begin
         txSub_q <= txSub_q + 4'h1;
         case (txSt_q)
            ST_START: begin
               txPin <= 1'b0;
               if (txSub_q == 4'hF) begin
                  txSt_q <= ST_DATA;
                  txIdx_q <= 3'h0;
               end
            end
            ST_DATA: begin
               txPin <= txSh_q[txIdx_q];
               if (txSub_q == 4'hF) begin
                  txIdx_q <= txIdx_q + 3'h1;
                  if (txIdx_q == 3'h7) begin
                     txSt_q <= ln.parEn ? ST_PAR : ST_STOP;
                     txStopN_q <= 1'b0;
                  end
               end
            end
            ST_PAR: begin
               txPin <= parityOf(txSh_q, ln.parOdd);
               if (txSub_q == 4'hF) begin
                  txSt_q <= ST_STOP;
                  txStopN_q <= 1'b0;
               end
            end
            // one or two idle-high stop bits
            ST_STOP: begin
               txPin <= 1'b1;
               if (txSub_q == 4'hF) begin
                  if (ln.stop2 && !txStopN_q) begin
                     txStopN_q <= 1'b1;
                  end else begin
                     txSt_q <= ST_IDLE;
                  end
               end
            end
            default: txSt_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Receiver: sync the pin, sample mid-bit
   // ------------------------------------------------------------------
   logic rxM_q;
   logic rxS_q;
   hufc_bit_t rxSt_q;
   logic [3:0] rxSub_q;
   logic [2:0] rxIdx_q;
   logic [7:0] rxSh_q;
   logic rxPe_q;
   logic rxDone_q;
   logic [7:0] rxByte_q;
   logic rxParErr_q;
   logic rxFrameErr_q;

   // only the host-driven line is sampled
   always_ff @(posedge clock) begin
      if (rst) begin
         rxM_q <= 1'b1;
         rxS_q <= 1'b1;
      end else begin
         rxM_q <= rxPin;
         rxS_q <= rxM_q;
      end
   end

   assign ln.rxDone = rxDone_q;
   assign ln.rxByte = rxByte_q;
   assign ln.rxParErr = rxParErr_q;
   assign ln.rxFrameErr = rxFrameErr_q;

   // receive frame, first stop bit checked
   always_ff @(posedge clock) begin
      if (rst) begin
         rxSt_q <= ST_IDLE;
         rxSub_q <= 4'h0;
         rxIdx_q <= 3'h0;
         rxSh_q <= 8'h00;
         rxPe_q <= 1'b0;
         rxDone_q <= 1'b0;
         rxByte_q <= 8'h00;
         rxParErr_q <= 1'b0;
         rxFrameErr_q <= 1'b0;
      end else begin
         rxDone_q <= 1'b0;
         if (rxSt_q == ST_IDLE) begin
            rxSub_q <= 4'h0;
            if (!rxS_q) begin
               rxSt_q <= ST_START;
            end
         end else if (ln.tick) begin
            rxSub_q <= rxSub_q + 4'h1;
            case (rxSt_q)
               // Glitch shorter than half a bit is dropped
               ST_START: begin
                  if (rxSub_q == 4'h7) begin
                     if (rxS_q) begin
                        rxSt_q <= ST_IDLE;
                     end else begin
                        rxSub_q <= 4'h0;
                        rxIdx_q <= 3'h0;
                        rxSt_q <= ST_DATA;
                     end
                  end
               end
               ST_DATA: begin
                  if (rxSub_q == 4'hF) begin
                     rxSh_q <= {rxS_q, rxSh_q[7:1]};
                     rxIdx_q <= rxIdx_q + 3'h1;
                     if (rxIdx_q == 3'h7) begin
                        rxSt_q <= ln.parEn ? ST_PAR : ST_STOP;
                     end
                  end
               end
               ST_PAR: begin
                  if (rxSub_q == 4'hF) begin
                     rxPe_q <= rxS_q;
                     rxSt_q <= ST_STOP;
                  end
               end
               ST_STOP: begin
                  if (rxSub_q == 4'hF) begin
                     rxDone_q <= 1'b1;
                     rxByte_q <= rxSh_q;
                     rxFrameErr_q <= !rxS_q;
                     rxParErr_q <= ln.parEn &&
                        (rxPe_q != parityOf(rxSh_q, ln.parOdd));
                     rxSt_q <= ST_IDLE;
                  end
               end
               default: rxSt_q <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_tx_idle_high: assert property (@(posedge clock) disable iff (rst)
      (txSt_q == ST_IDLE && $past(txSt_q) == ST_IDLE) |-> txPin)
      else $error("tx line not high while idle");
   // Pin updates on the first tick in the state, so skip until then
   a_stop_high: assert property (@(posedge clock) disable iff (rst)
      (txSt_q == ST_STOP && $past(txSt_q) == ST_STOP
       && $past(txSub_q) != 4'h0) |-> txPin)
      else $error("stop bit not high");
   a_start_low: assert property (@(posedge clock) disable iff (rst)
      (txSt_q == ST_START && $past(txSt_q) == ST_START
       && $past(txSub_q) != 4'h0) |-> !txPin)
      else $error("start bit not low");
   c_rx_frame: cover property (@(posedge clock) rxDone_q && !rxFrameErr_q);
   c_tx_two_stop: cover property (@(posedge clock)
      txSt_q == ST_STOP && txStopN_q);

endmodule
`default_nettype wire

// File: hufc_uart.sv
// Host UART top: APB registers, baud divider, flow control
// What this block does
// - Separate transmit and receive data lines
// - Request and clear to send active low
// - Module drives request-to-send readiness output
// - Rate selectable 1200 to 625000 bps (divisor 1 at the 10 MHz clock)
// - Flow control hardware handshake or none
// - Exactly eight data bits per frame
// - Parity none, odd or even
// - One or two high stop bits
// - Transport framing support switchable independently
// - Defaults 115200, no flow, 8N1
`timescale 1ns/1ps
`default_nettype none
module hufc_uart (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic uartRxPin,
   output logic uartTxPin,
   input wire logic ctsPin_n,
   output logic rtsPin_n,
   output logic framingEnable
);

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [4:0] ctrl_q;
   logic [15:0] baudDiv_q;
   logic [15:0] divCnt_q;
   logic [7:0] txHold_q;
   logic txFull_q;
   logic [7:0] rxHold_q;
   logic rxValid_q;
   logic parErr_q;
   logic frameErr_q;
   logic overrun_q;
   logic ctsM_q;
   logic ctsS_q;
   logic tick;

   hufc_line_if ln ();

   hufc_serial_engine u_engine (
      .clock(clock),
      .rst(rst),
      .rxPin(uartRxPin),
      .txPin(uartTxPin),
      .ln(ln)
   );

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   // Unmapped or misaligned offsets answer with an error
   function automatic logic addrOk(input logic [7:0] a);
      addrOk = (a == hufc_pkg::ADDR_CTRL) || (a == hufc_pkg::ADDR_BAUD) ||
         (a == hufc_pkg::ADDR_TXDATA) || (a == hufc_pkg::ADDR_RXDATA) ||
         (a == hufc_pkg::ADDR_STATUS);
   endfunction

   logic access;
   logic wrOk;
   logic rdOk;
   assign access = psel && penable;
   assign wrOk = access && pwrite && addrOk(paddr);
   assign rdOk = access && !pwrite && addrOk(paddr);
   // Zero wait states
   assign pready = 1'b1;
   assign pslverr = access && !addrOk(paddr);

   // ------------------------------------------------------------------
   // Configuration
   // ------------------------------------------------------------------
   // power-up format and rate
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= hufc_pkg::CTRL_RESET;
         baudDiv_q <= hufc_pkg::BAUD_DIV_RESET;
      end else if (wrOk && paddr == hufc_pkg::ADDR_CTRL) begin
         ctrl_q <= pwdata[4:0];
      end else if (wrOk && paddr == hufc_pkg::ADDR_BAUD) begin
         // zero divisor clamped to fastest rate
         baudDiv_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
   end

   logic flowOn;
   assign flowOn = ctrl_q[hufc_pkg::CTRL_FLOW];
   assign ln.parEn = ctrl_q[hufc_pkg::CTRL_PAREN];
   assign ln.parOdd = ctrl_q[hufc_pkg::CTRL_PARODD];
   assign ln.stop2 = ctrl_q[hufc_pkg::CTRL_STOP2];

   // transport framing switch, separate from format
   always_ff @(posedge clock) begin
      if (rst) begin
         framingEnable <= 1'b0;
      end else begin
         framingEnable <= ctrl_q[hufc_pkg::CTRL_FRAMING];
      end
   end

   // ------------------------------------------------------------------
   // Baud tick divider (16 ticks per bit)
   // ------------------------------------------------------------------
   // rate set by divisor register
   always_ff @(posedge clock) begin
      if (rst) begin
         divCnt_q <= 16'h0000;
         tick <= 1'b0;
      end else if (divCnt_q >= baudDiv_q - 16'h0001) begin
         divCnt_q <= 16'h0000;
         tick <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 16'h0001;
         tick <= 1'b0;
      end
   end
   assign ln.tick = tick;

   // ------------------------------------------------------------------
   // Clear-to-send synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         ctsM_q <= 1'b1;
         ctsS_q <= 1'b1;
      end else begin
         ctsM_q <= ctsPin_n;
         ctsS_q <= ctsM_q;
      end
   end

   // ------------------------------------------------------------------
   // Transmit holding register
   // ------------------------------------------------------------------
   logic txAllowed;
   assign txAllowed = !flowOn || !ctsS_q;
   // start only; a running character always completes
   assign ln.txGo = txFull_q && !ln.txBusy && txAllowed;
   assign ln.txByte = txHold_q;

   // Writes while full are dropped; software polls the full flag
   always_ff @(posedge clock) begin
      if (rst) begin
         txHold_q <= 8'h00;
         txFull_q <= 1'b0;
      end else if (ln.txGo) begin
         txFull_q <= 1'b0;
      end else if (wrOk && paddr == hufc_pkg::ADDR_TXDATA && !txFull_q) begin
         txHold_q <= pwdata[7:0];
         txFull_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Receive holding register and error flags
   // ------------------------------------------------------------------
   logic rxRead;
   assign rxRead = rdOk && paddr == hufc_pkg::ADDR_RXDATA;

   // Set wins over clear for all sticky flags
   always_ff @(posedge clock) begin
      if (rst) begin
         rxHold_q <= 8'h00;
         rxValid_q <= 1'b0;
      end else if (ln.rxDone && (!rxValid_q || rxRead)) begin
         rxHold_q <= ln.rxByte;
         rxValid_q <= 1'b1;
      end else if (rxRead) begin
         rxValid_q <= 1'b0;
      end
   end

   // Error flags clear by writing one to the status bit
   logic w1c;
   assign w1c = wrOk && paddr == hufc_pkg::ADDR_STATUS;
   always_ff @(posedge clock) begin
      if (rst) begin
         parErr_q <= 1'b0;
         frameErr_q <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         parErr_q <= (ln.rxDone && ln.rxParErr) ||
            (parErr_q && !(w1c && pwdata[hufc_pkg::STAT_PARERR]));
         frameErr_q <= (ln.rxDone && ln.rxFrameErr) ||
            (frameErr_q && !(w1c && pwdata[hufc_pkg::STAT_FRAMERR]));
         overrun_q <= (ln.rxDone && rxValid_q && !rxRead) ||
            (overrun_q && !(w1c && pwdata[hufc_pkg::STAT_OVERRUN]));
      end
   end

   // ------------------------------------------------------------------
   // Request-to-send
   // ------------------------------------------------------------------
   // with flow on, low only while holding register is free
   // active low; held low with flow off
   always_ff @(posedge clock) begin
      if (rst) begin
         rtsPin_n <= 1'b1;
      end else begin
         rtsPin_n <= flowOn && rxValid_q;
      end
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[hufc_pkg::STAT_TXBUSY] = ln.txBusy;
      status[hufc_pkg::STAT_TXFULL] = txFull_q;
      status[hufc_pkg::STAT_RXVALID] = rxValid_q;
      status[hufc_pkg::STAT_PARERR] = parErr_q;
      status[hufc_pkg::STAT_FRAMERR] = frameErr_q;
      status[hufc_pkg::STAT_OVERRUN] = overrun_q;
      status[hufc_pkg::STAT_CTSLOW] = !ctsS_q;
      status[hufc_pkg::STAT_RTSLOW] = !rtsPin_n;
   end

   // Read data registered at setup, stable in the access phase
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            hufc_pkg::ADDR_CTRL: prdata <= {27'h000_0000, ctrl_q};
            hufc_pkg::ADDR_BAUD: prdata <= {16'h0000, baudDiv_q};
            hufc_pkg::ADDR_RXDATA: prdata <= {24'h00_0000, rxHold_q};
            hufc_pkg::ADDR_STATUS: prdata <= {24'h00_0000, status};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_cts_gates_tx: assert property (@(posedge clock) disable iff (rst)
      (ln.txGo && flowOn) |-> !ctsS_q)
      else $error("transmit started without clear-to-send");
   a_rts_full: assert property (@(posedge clock) disable iff (rst)
      (flowOn && rxValid_q) |=> rtsPin_n || $past(rxRead))
      else $error("request-to-send low while buffer full");
   // Sampled reset excluded: the pin is still high one edge after release
   a_rts_noflow: assert property (@(posedge clock) disable iff (rst)
      (!flowOn && !rst) [*2] |-> !rtsPin_n)
      else $error("request-to-send high with flow off");
   a_tick_period: assert property (@(posedge clock) disable iff (rst)
      ($rose(tick) && $stable(baudDiv_q) && baudDiv_q > 16'h0001)
      |=> !tick)
      else $error("baud tick too frequent");
   // Checked on the first edge out of reset, not before the first edge
   a_reset_format: assert property (@(posedge clock)
      ($past(rst) && !rst) |-> ctrl_q == hufc_pkg::CTRL_RESET
         && baudDiv_q == hufc_pkg::BAUD_DIV_RESET)
      else $error("reset format wrong");
   c_tx_go: cover property (@(posedge clock) ln.txGo && flowOn);
   c_overrun: cover property (@(posedge clock) $rose(overrun_q));

endmodule
`default_nettype wire

// File: hufc_host_model.sv
// Host side partner: sends frames to the port and checks its frames
`timescale 1ns/1ps
`default_nettype none
module hufc_host_model (
   input wire logic clock,
   input wire logic fromDev,
   output logic toDev
);
   int bitClks = 80;
   bit parEn = 1'b0;
   bit parOdd = 1'b0;
   bit stop2 = 1'b0;
   int badFrames = 0;
   logic [7:0] rxSh;
   logic [7:0] gotQ[$];

   // -----------------------------------------------------------------
   // Sender
   // -----------------------------------------------------------------
   // Line idles high between frames
   initial toDev = 1'b1;

   task automatic send(input logic [7:0] b, input bit badPar);
      logic [11:0] f;
      int n;
      f = parEn ? {2'b11, ^b ^ parOdd ^ badPar, b, 1'b0} : {3'b111, b, 1'b0};
      n = 10 + int'(parEn) + int'(stop2);
      for (int i = 0; i < n; i++) begin
         toDev <= f[i];
         repeat (bitClks) @(posedge clock);
      end
   endtask

   // -----------------------------------------------------------------
   // Receiver
   // -----------------------------------------------------------------
   // sample mid bit, stops high
   always begin
      @(negedge fromDev);
      repeat (bitClks / 2) @(posedge clock);
      if (fromDev !== 1'b0) badFrames++;
      for (int i = 0; i < 8; i++) begin
         repeat (bitClks) @(posedge clock);
         rxSh[i] = fromDev;
      end
      if (parEn) begin
         repeat (bitClks) @(posedge clock);
         if (fromDev !== (^rxSh ^ parOdd)) badFrames++;
      end
      // Second stop checked too: a short gap shows up here
      for (int i = 0; i < (stop2 ? 2 : 1); i++) begin
         repeat (bitClks) @(posedge clock);
         if (fromDev !== 1'b1) badFrames++;
      end
      gotQ.push_back(rxSh);
   end
endmodule
`default_nettype wire

// File: testbench.sv
// Testbench for the host UART: APB driver, host model, scoreboard
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      nChecks++; \
      if ((g) !== (e)) begin \
         failCount++; \
         $display("unexpected %s exp %h got %h", nm, e, g); \
      end \
   end
module testbench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic ctsPin_n = 1'b0;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, uartRxPin, uartTxPin, rtsPin_n, framingEnable;
   logic lastErr;
   logic [7:0] expQ[$];
   int failCount = 0;
   int nChecks = 0;

   // 100 ns clock
   always #50 clock = ~clock;

   hufc_uart dut (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uartRxPin(uartRxPin), .uartTxPin(uartTxPin), .ctsPin_n(ctsPin_n),
      .rtsPin_n(rtsPin_n), .framingEnable(framingEnable));
   hufc_host_model host (.clock(clock), .fromDev(uartTxPin),
      .toDev(uartRxPin));

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdv = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic tx_push(input logic [7:0] v);
      apb(1'b1, hufc_pkg::ADDR_TXDATA, {24'h00_0000, v});
      expQ.push_back(v);
   endtask

   // Wait for the host to collect every queued byte, then compare
   task automatic tx_drain();
      int k;
      logic [7:0] e, g;
      k = 0;
      while (host.gotQ.size() < expQ.size() && k < 9000) begin
         @(posedge clock);
         k++;
      end
      while (expQ.size() > 0) begin
         e = expQ.pop_front();
         g = host.gotQ.size() > 0 ? host.gotQ.pop_front() : 8'hxx;
         `CHK("txbyte", e, g)
      end
      `CHK("badframes", 0, host.badFrames)
   endtask

   task automatic rx_check(input logic [7:0] v, input logic bad);
      host.send(v, bad);
      apb(1'b0, hufc_pkg::ADDR_STATUS, 32'h0000_0000);
      `CHK("rxvalid", 1'b1, rdv[hufc_pkg::STAT_RXVALID])
      `CHK("parerr", bad, rdv[hufc_pkg::STAT_PARERR])
      apb(1'b0, hufc_pkg::ADDR_RXDATA, 32'h0000_0000);
      `CHK("rxbyte", v, rdv[7:0])
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog, well beyond the roughly 10000 cycles needed
   initial begin
      repeat (60000) @(posedge clock);
      failCount++;
      tally_and_finish();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      void'($urandom(32'h864a_5523));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      apb(1'b0, hufc_pkg::ADDR_CTRL, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0000, rdv)
      apb(1'b0, hufc_pkg::ADDR_BAUD, 32'h0000_0000);
      `CHK("baud", {16'h0000, hufc_pkg::BAUD_DIV_RESET}, rdv)
      `CHK("idle", 1'b1, uartTxPin)
      `CHK("rtsoff", 1'b0, rtsPin_n)
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK("slverr", 1'b1, lastErr)
      // Default format at the reset divisor
      tx_push(8'($urandom()));
      tx_drain();
      rx_check(8'($urandom()), 1'b0);
      `CHK("framing", 1'b0, framingEnable)
      $display("test defaults done");
      // Every parity and stop combination; parity frames at divisor 2, no-parity frames at divisor 1
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, hufc_pkg::ADDR_BAUD, 32'(m % 2 + 1));
         apb(1'b1, hufc_pkg::ADDR_CTRL, 32'(m << 1));
         host.bitClks = 16 * (m % 2 + 1);
         host.parEn = m[0];
         host.parOdd = m[1];
         host.stop2 = m[2];
         tx_push(8'($urandom()));
         tx_push(8'($urandom()));
         tx_drain();
         rx_check(8'($urandom()), 1'b0);
      end
      rx_check(8'($urandom()), 1'b1);
      apb(1'b1, hufc_pkg::ADDR_STATUS, 32'h0000_0008);
      apb(1'b0, hufc_pkg::ADDR_STATUS, 32'h0000_0000);
      `CHK("parclr", 1'b0, rdv[hufc_pkg::STAT_PARERR])
      $display("test formats done");
      // Framing switch leaves the character format alone
      apb(1'b1, hufc_pkg::ADDR_CTRL, 32'h0000_001E);
      tx_push(8'($urandom()));
      tx_drain();
      `CHK("framing", 1'b1, framingEnable)
      $display("test framing done");
      apb(1'b1, hufc_pkg::ADDR_BAUD, 32'h0000_0001);
      apb(1'b1, hufc_pkg::ADDR_CTRL, 32'h0000_0001);
      host.bitClks = 16;
      host.parEn = 1'b0;
      host.stop2 = 1'b0;
      `CHK("rtsroom", 1'b0, rtsPin_n)
      // host withholds clear-to-send by driving high
      ctsPin_n <= 1'b1;
      tx_push(8'($urandom()));
      repeat (400) @(posedge clock);
      `CHK("held", 0, host.gotQ.size())
      ctsPin_n <= 1'b0;
      tx_drain();
      host.send(8'($urandom()), 1'b0);
      repeat (2) @(posedge clock);
      `CHK("rtsfull", 1'b1, rtsPin_n)
      apb(1'b0, hufc_pkg::ADDR_RXDATA, 32'h0000_0000);
      repeat (3) @(posedge clock);
      `CHK("rtsback", 1'b0, rtsPin_n)
      // Withdraw clearance in mid character
      tx_push(8'($urandom()));
      repeat (64) @(posedge clock);
      ctsPin_n <= 1'b1;
      tx_drain();
      apb(1'b1, hufc_pkg::ADDR_CTRL, 32'h0000_0000);
      tx_push(8'($urandom()));
      tx_drain();
      ctsPin_n <= 1'b0;
      $display("test flow done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
